// ===== hw/vrs_pkg.sv
// package: shared constants, settings carriers and states of the sequencer
package vrs_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 25_000_000; // core clock rate
  localparam int unsigned TICK_MS = 10; // timer resolution, 0.01 s
  // cycles per timer tick, default of the top parameter
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned RESET_WIN_MS = 1000; // reset interval, 1 s
  localparam logic [14:0] RESET_WIN_TICKS = 15'(RESET_WIN_MS / TICK_MS);

  // ***************************************************************
  // setting widths, ranges and defaults (delays in ticks)
  // ***************************************************************
  localparam int unsigned DLY_W = 15; // delay width in ticks
  localparam int unsigned VOLT_W = 16; // voltage sample width
  localparam logic [DLY_W-1:0] DLY_MIN = 15'h000A; // 0.10 s
  localparam logic [DLY_W-1:0] LV_RCL_MAX = 15'h4650; // 180.00 s
  localparam logic [DLY_W-1:0] HV_RCL_MAX = 15'h7530; // 300.00 s
  localparam logic [DLY_W-1:0] TRIP_DLY_MAX = 15'h2710; // 100.00 s
  localparam logic [DLY_W-1:0] DLY_DEF = 15'h03E8; // 10.00 s
  localparam logic [7:0] HV_FAC_MIN = 8'h64; // 1.00
  localparam logic [7:0] HV_FAC_MAX = 8'h8C; // 1.40
  localparam logic [7:0] HV_FAC_DEF = 8'h69; // 1.05
  localparam logic [7:0] LV_FAC_MIN = 8'h3C; // 0.60
  localparam logic [7:0] LV_FAC_MAX = 8'h64; // 1.00
  localparam logic [7:0] LV_FAC_DEF = 8'h50; // 0.80
  localparam logic [6:0] FAC_SCALE = 7'h64; // factor unit, hundredths
  localparam logic LIMIT_TWO_DEF = 1'b0; // one trip to lockout
  localparam logic TRIP_EN_DEF = 1'b0; // trip elements disabled
  localparam int unsigned NUM_CHK = 5; // supply quality checks

  // ***************************************************************
  // carriers
  // ***************************************************************
  // trip element settings of one source direction
  typedef struct packed {
    logic en;
    logic [7:0] factor;
    logic [DLY_W-1:0] delay;
  } vrs_trip_set_s;

  // reclose controller settings of one source direction
  typedef struct packed {
    logic limit_two;
    logic [DLY_W-1:0] delay;
  } vrs_rcl_set_s;

  // reclose controller states
  typedef enum logic [2:0] {
    ST_LOCK = 3'h0,
    ST_RESET_WIN = 3'h1,
    ST_PASSIVE = 3'h2,
    ST_TRIP_PEND = 3'h3,
    ST_WAIT_SUPPLY = 3'h4,
    ST_RCL_TIME = 3'h5,
    ST_CLOSE_PEND = 3'h6
  } vrs_rcl_state_e;

  // clamp a delay into its range
  function automatic logic [DLY_W-1:0] clamp_dly(
    input logic [DLY_W-1:0] v,
    input logic [DLY_W-1:0] hi
  );
    clamp_dly = (v < DLY_MIN) ? DLY_MIN : ((v > hi) ? hi : v);
  endfunction

  // clamp a threshold factor into its range
  function automatic logic [7:0] clamp_fac(
    input logic [7:0] v,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    clamp_fac = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

// ===== hw/vrs_tick_div.sv
// module: divider giving a one-cycle enable every timer tick
`timescale 1ns/100ps
module vrs_tick_div #(
  parameter int unsigned TICK_CYC = vrs_pkg::TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  output logic o_tick
);

  // cycle counter within a tick
  logic [17:0] cnt_q;
  logic [17:0] cnt_d;
  logic wrap; // last cycle of a tick
  logic tick_q; // registered tick pulse

  assign wrap = (cnt_q == 18'(TICK_CYC - 1));
  assign cnt_d = wrap ? 18'h00000 : cnt_q + 18'h00001;
  assign o_tick = tick_q;

  // count cycles and pulse on wrap
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end

endmodule

// ===== hw/vrs_trip_elem.sv
// module: voltage trip element with threshold factor and trip delay
`timescale 1ns/100ps
module vrs_trip_elem #(
  parameter bit OVER = 1'b0 // 1: trips on high voltage, 0: low
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire logic [15:0] i_volt, // positive sequence source voltage
  input wire logic [15:0] i_phase_volt, // rated phase voltage
  input wire vrs_pkg::vrs_trip_set_s i_set,
  input wire logic i_block, // protection off
  output logic o_pick, // condition present, trip delay running
  output logic o_trip // one-cycle trip request
);

  logic [23:0] meas; // voltage times factor scale
  logic [23:0] thr; // phase voltage times factor
  logic cond; // pickup condition
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic done_q; // trip already requested for this pickup
  logic trip_q;
  logic expire;

  assign meas = 24'(i_volt) * 24'(vrs_pkg::FAC_SCALE);
  assign thr = 24'(i_phase_volt) * 24'(i_set.factor);
  // compare against threshold, enabled and not blocked
  assign cond = i_set.en && !i_block &&
                (OVER ? (meas > thr) : (meas < thr));
  assign expire = cond && i_tick && !done_q &&
                  (cnt_q >= i_set.delay);
  // counter clears when condition drops, saturates at the top
  assign cnt_d = !cond ? 15'h0000 :
                 (i_tick && cnt_q != 15'h7FFF) ? cnt_q + 15'h0001 : cnt_q;
  assign o_pick = cond && !done_q;
  assign o_trip = trip_q;

  // trip delay timer and one-shot trip request
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cnt_q <= 15'h0000;
      done_q <= 1'b0;
      trip_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      trip_q <= expire;
      done_q <= cond && (done_q || expire);
    end
  end

endmodule

// ===== hw/vrs_top.sv
// module: voltage trip elements and reclose sequencers of a recloser
`timescale 1ns/100ps
module vrs_top #(
  parameter int unsigned TICK_CYC = vrs_pkg::TICK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  // measurements from the measuring unit
  input wire logic [15:0] i_pos_seq_voltage_src_a,
  input wire logic [15:0] i_phase_volt,
  // supply quality checks: enable and within-limit flags
  input wire logic [4:0] i_chk_en,
  input wire logic [4:0] i_chk_ok,
  // recloser open state from the actuator driver, asynchronous
  input wire logic i_rec_open,
  // operator commands
  input wire logic i_live_work,
  input wire logic i_prot_off,
  input wire logic i_reclose_off,
  // source direction for ring use: 0 plus, 1 minus
  input wire logic i_src_minus,
  // settings load strobe and new settings
  input wire logic i_set_load,
  input wire vrs_pkg::vrs_trip_set_s i_lv_trip_plus,
  input wire vrs_pkg::vrs_trip_set_s i_lv_trip_minus,
  input wire vrs_pkg::vrs_trip_set_s i_hv_trip_plus,
  input wire vrs_pkg::vrs_trip_set_s i_hv_trip_minus,
  input wire vrs_pkg::vrs_rcl_set_s i_lv_rcl_plus,
  input wire vrs_pkg::vrs_rcl_set_s i_lv_rcl_minus,
  input wire vrs_pkg::vrs_rcl_set_s i_hv_rcl_plus,
  input wire vrs_pkg::vrs_rcl_set_s i_hv_rcl_minus,
  // requests to the actuator driver
  output logic o_trip_req,
  output logic o_close_req,
  // status
  output logic o_supply_good,
  output vrs_pkg::vrs_rcl_state_e o_lv_state,
  output vrs_pkg::vrs_rcl_state_e o_hv_state,
  output logic o_lv_pick,
  output logic o_hv_pick
);

  // ***************************************************************
  // settings storage
  // ***************************************************************
  // index 0 plus direction, 1 minus direction
  vrs_pkg::vrs_trip_set_s lv_trip_q [2]; // low element settings
  vrs_pkg::vrs_trip_set_s hv_trip_q [2]; // high element settings
  vrs_pkg::vrs_rcl_set_s rcl_q [2][2]; // [controller][direction]
  vrs_pkg::vrs_trip_set_s lv_trip_def; // low element defaults
  vrs_pkg::vrs_trip_set_s hv_trip_def; // high element defaults
  vrs_pkg::vrs_rcl_set_s rcl_def; // controller defaults
  vrs_pkg::vrs_trip_set_s lv_in [2]; // clamped new low settings
  vrs_pkg::vrs_trip_set_s hv_in [2]; // clamped new high settings
  vrs_pkg::vrs_rcl_set_s rcl_in [2][2]; // clamped new reclose settings
  logic [14:0] rcl_max [2]; // reclose delay ceiling per controller

  assign lv_trip_def = '{en: vrs_pkg::TRIP_EN_DEF,
                         factor: vrs_pkg::LV_FAC_DEF,
                         delay: vrs_pkg::DLY_DEF};
  assign hv_trip_def = '{en: vrs_pkg::TRIP_EN_DEF,
                         factor: vrs_pkg::HV_FAC_DEF,
                         delay: vrs_pkg::DLY_DEF};
  assign rcl_def = '{limit_two: vrs_pkg::LIMIT_TWO_DEF,
                     delay: vrs_pkg::DLY_DEF};
  assign rcl_max[0] = vrs_pkg::LV_RCL_MAX;
  assign rcl_max[1] = vrs_pkg::HV_RCL_MAX;

  // clamp low element settings into range
  assign lv_in[0] = '{en: i_lv_trip_plus.en,
    factor: vrs_pkg::clamp_fac(i_lv_trip_plus.factor,
      vrs_pkg::LV_FAC_MIN, vrs_pkg::LV_FAC_MAX),
    delay: vrs_pkg::clamp_dly(i_lv_trip_plus.delay,
      vrs_pkg::TRIP_DLY_MAX)};
  assign lv_in[1] = '{en: i_lv_trip_minus.en,
    factor: vrs_pkg::clamp_fac(i_lv_trip_minus.factor,
      vrs_pkg::LV_FAC_MIN, vrs_pkg::LV_FAC_MAX),
    delay: vrs_pkg::clamp_dly(i_lv_trip_minus.delay,
      vrs_pkg::TRIP_DLY_MAX)};
  // clamp high element settings, own set per direction
  assign hv_in[0] = '{en: i_hv_trip_plus.en,
    factor: vrs_pkg::clamp_fac(i_hv_trip_plus.factor,
      vrs_pkg::HV_FAC_MIN, vrs_pkg::HV_FAC_MAX),
    delay: vrs_pkg::clamp_dly(i_hv_trip_plus.delay,
      vrs_pkg::TRIP_DLY_MAX)};
  assign hv_in[1] = '{en: i_hv_trip_minus.en,
    factor: vrs_pkg::clamp_fac(i_hv_trip_minus.factor,
      vrs_pkg::HV_FAC_MIN, vrs_pkg::HV_FAC_MAX),
    delay: vrs_pkg::clamp_dly(i_hv_trip_minus.delay,
      vrs_pkg::TRIP_DLY_MAX)};
  // clamp reclose settings, own set per direction
  assign rcl_in[0][0] = '{limit_two: i_lv_rcl_plus.limit_two,
    delay: vrs_pkg::clamp_dly(i_lv_rcl_plus.delay, rcl_max[0])};
  assign rcl_in[0][1] = '{limit_two: i_lv_rcl_minus.limit_two,
    delay: vrs_pkg::clamp_dly(i_lv_rcl_minus.delay,
      rcl_max[0])};
  assign rcl_in[1][0] = '{limit_two: i_hv_rcl_plus.limit_two,
    delay: vrs_pkg::clamp_dly(i_hv_rcl_plus.delay, rcl_max[1])};
  assign rcl_in[1][1] = '{limit_two: i_hv_rcl_minus.limit_two,
    delay: vrs_pkg::clamp_dly(i_hv_rcl_minus.delay, rcl_max[1])};

  // settings reset to defaults, replaced on load strobe
  always_ff @(posedge i_core_clk)
  begin
    for (int d = 0; d < 2; d++)
    begin
      if (i_srst)
      begin
        lv_trip_q[d] <= lv_trip_def;
        hv_trip_q[d] <= hv_trip_def;
        rcl_q[0][d] <= rcl_def;
        rcl_q[1][d] <= rcl_def;
      end
      else if (i_set_load)
      begin
        lv_trip_q[d] <= lv_in[d];
        hv_trip_q[d] <= hv_in[d];
        rcl_q[0][d] <= rcl_in[0][d];
        rcl_q[1][d] <= rcl_in[1][d];
      end
    end
  end

  // ***************************************************************
  // open state synchroniser and supply quality gate
  // ***************************************************************
  logic open_m1_q; // first stage, read only by the second
  logic open_m2_q;
  logic open_m3_q;
  logic open_q; // filtered open state
  logic good_q; // supply good verdict

  // three stages, accept a change once stages two and three agree
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      open_m1_q <= 1'b1;
      open_m2_q <= 1'b1;
      open_m3_q <= 1'b1;
      open_q <= 1'b1;
      good_q <= 1'b0;
    end
    else
    begin
      open_m1_q <= i_rec_open;
      open_m2_q <= open_m1_q;
      open_m3_q <= open_m2_q;
      if (open_m2_q == open_m3_q)
      begin
        open_q <= open_m3_q;
      end
      good_q <= &(~i_chk_en | i_chk_ok);
    end
  end

  assign o_supply_good = good_q;

  // ***************************************************************
  // tick divider and trip elements
  // ***************************************************************
  logic tick; // one pulse per 0.01 s
  logic [1:0] pick; // [0] low, [1] high element timing
  logic [1:0] trip; // [0] low, [1] high trip pulse
  logic dir; // active source direction
  logic force_lock; // operator forced lockout
  logic trip_q;
  logic close_q;
  logic [1:0] close_d; // close request per controller

  assign dir = i_src_minus;
  assign force_lock = i_live_work || i_prot_off || i_reclose_off;

  vrs_tick_div #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .o_tick(tick)
  );

  vrs_trip_elem #(
    .OVER(1'b0)
  ) u_lv_elem (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_tick(tick),
    .i_volt(i_pos_seq_voltage_src_a),
    .i_phase_volt(i_phase_volt),
    .i_set(lv_trip_q[dir]),
    .i_block(i_prot_off),
    .o_pick(pick[0]),
    .o_trip(trip[0])
  );

  vrs_trip_elem #(
    .OVER(1'b1)
  ) u_hv_elem (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_tick(tick),
    .i_volt(i_pos_seq_voltage_src_a),
    .i_phase_volt(i_phase_volt),
    .i_set(hv_trip_q[dir]),
    .i_block(i_prot_off),
    .o_pick(pick[1]),
    .o_trip(trip[1])
  );

  // ***************************************************************
  // reclose controllers: 0 low voltage, 1 high voltage
  // ***************************************************************
  vrs_pkg::vrs_rcl_state_e st_q [2];

  for (genvar k = 0; k < 2; k++)
  begin : g_rcl
    vrs_pkg::vrs_rcl_state_e st_d;
    vrs_pkg::vrs_rcl_set_s set; // active direction settings
    logic [14:0] cnt_q; // reset window or reclose delay timer
    logic [14:0] cnt_d;
    logic run; // timer advances on tick
    logic win_done; // reset window complete
    logic dly_done; // reclose delay complete

    assign set = rcl_q[k][dir];
    // reset timer held while own element times its trip delay
    assign run = (st_q[k] == vrs_pkg::ST_RESET_WIN && !pick[k]) ||
                 (st_q[k] == vrs_pkg::ST_RCL_TIME);
    assign win_done = tick && !pick[k] &&
                      (cnt_q >= vrs_pkg::RESET_WIN_TICKS);
    assign dly_done = tick && (cnt_q >= set.delay);
    // clear timer on each state change
    assign cnt_d = (st_d != st_q[k]) ? 15'h0000 :
                   (run && tick && cnt_q != 15'h7FFF) ?
                   cnt_q + 15'h0001 : cnt_q;

    // next state of the sequence
    always_comb
    begin
      st_d = st_q[k];
      close_d[k] = 1'b0;
      if (force_lock)
      begin
        st_d = vrs_pkg::ST_LOCK;
      end
      else
      begin
        unique case (st_q[k])
          // open to lockout: a closing restarts the window
          vrs_pkg::ST_LOCK:
            if (!open_q)
            begin
              st_d = vrs_pkg::ST_RESET_WIN;
            end
          // first closing or after reclosure: single shot window
          vrs_pkg::ST_RESET_WIN:
            if (trip[k] || open_q)
            begin
              st_d = vrs_pkg::ST_LOCK;
            end
            else if (win_done)
            begin
              st_d = vrs_pkg::ST_PASSIVE;
            end
          // passive: full sequence available
          vrs_pkg::ST_PASSIVE:
            if (trip[k])
            begin
              st_d = set.limit_two ? vrs_pkg::ST_TRIP_PEND :
                     vrs_pkg::ST_LOCK;
            end
            else if (open_q)
            begin
              st_d = vrs_pkg::ST_LOCK;
            end
          // trip requested, wait for the recloser to open
          vrs_pkg::ST_TRIP_PEND:
            if (open_q)
            begin
              st_d = vrs_pkg::ST_WAIT_SUPPLY;
            end
          // trip to reclose: hold until supply is good
          vrs_pkg::ST_WAIT_SUPPLY:
            if (!open_q)
            begin
              st_d = vrs_pkg::ST_RESET_WIN;
            end
            else if (good_q)
            begin
              st_d = vrs_pkg::ST_RCL_TIME;
            end
          // timing reclose delay, restart on supply failure
          vrs_pkg::ST_RCL_TIME:
            if (!good_q)
            begin
              st_d = vrs_pkg::ST_WAIT_SUPPLY;
            end
            else if (dly_done)
            begin
              close_d[k] = 1'b1;
              st_d = vrs_pkg::ST_CLOSE_PEND;
            end
          // close requested, wait for the recloser to close
          vrs_pkg::ST_CLOSE_PEND:
            if (!open_q)
            begin
              st_d = vrs_pkg::ST_RESET_WIN;
            end
          // unused code: recover to lockout
          default:
            st_d = vrs_pkg::ST_LOCK;
        endcase
      end
    end

    // state and timer registers
    always_ff @(posedge i_core_clk)
    begin
      if (i_srst)
      begin
        st_q[k] <= vrs_pkg::ST_LOCK;
        cnt_q <= 15'h0000;
      end
      else
      begin
        st_q[k] <= st_d;
        cnt_q <= cnt_d;
      end
    end
  end

  // ***************************************************************
  // driver requests and status
  // ***************************************************************
  // registered request pulses to the actuator driver
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      trip_q <= 1'b0;
      close_q <= 1'b0;
    end
    else
    begin
      trip_q <= |trip;
      close_q <= |close_d;
    end
  end

  assign o_trip_req = trip_q;
  assign o_close_req = close_q;
  assign o_lv_state = st_q[0];
  assign o_hv_state = st_q[1];
  assign o_lv_pick = pick[0];
  assign o_hv_pick = pick[1];

endmodule

// ===== dv/vrs_top_asserts.sv
// checker: port timing relations of the reclose sequencer
`timescale 1ns/100ps
module vrs_top_chk #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [4:0] i_chk_en,
  input wire logic [4:0] i_chk_ok,
  input wire logic i_live_work,
  input wire logic i_prot_off,
  input wire logic i_reclose_off,
  input wire logic o_trip_req,
  input wire logic o_close_req,
  input wire logic o_supply_good,
  input wire vrs_pkg::vrs_rcl_state_e o_lv_state,
  input wire vrs_pkg::vrs_rcl_state_e o_hv_state,
  input wire logic o_lv_pick,
  input wire logic o_hv_pick
);
  // ************************************************
  // helper logic and assertions
  // ************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  logic [31:0] win_q; // cycles spent in the low reset window
  // count only while the low controller sits in its window
  always_ff @(posedge i_core_clk)
  begin
    if (o_lv_state == vrs_pkg::ST_RESET_WIN)
      win_q <= win_q + 32'h1;
    else
      win_q <= '0;
  end
  a_trip_pulse: assert property (o_trip_req |=> !o_trip_req)
    else $error("trip request longer than one cycle");
  a_close_cause: assert property (o_close_req |->
    $past(o_lv_state) == vrs_pkg::ST_RCL_TIME
    && o_lv_state == vrs_pkg::ST_CLOSE_PEND
    || $past(o_hv_state) == vrs_pkg::ST_RCL_TIME
    && o_hv_state == vrs_pkg::ST_CLOSE_PEND)
    else $error("close request without reclose timing");
  a_cmd_lockout: assert property (
    i_live_work || i_prot_off || i_reclose_off |=>
    o_lv_state == vrs_pkg::ST_LOCK && o_hv_state == vrs_pkg::ST_LOCK)
    else $error("command did not force lockout");
  a_lv_win_hold: assert property (
    o_lv_state == vrs_pkg::ST_RESET_WIN && o_lv_pick |=>
    o_lv_state != vrs_pkg::ST_PASSIVE)
    else $error("low window ended while element timing");
  a_hv_win_hold: assert property (
    o_hv_state == vrs_pkg::ST_RESET_WIN && o_hv_pick |=>
    o_hv_state != vrs_pkg::ST_PASSIVE)
    else $error("high window ended while element timing");
  a_pend_source: assert property (
    o_lv_state == vrs_pkg::ST_TRIP_PEND |->
    $past(o_lv_state) inside {vrs_pkg::ST_PASSIVE, vrs_pkg::ST_TRIP_PEND})
    else $error("trip to reclose entered from window");
  a_supply_gate: assert property (!$past(i_srst) |->
    o_supply_good == $past(&(~i_chk_en | i_chk_ok)))
    else $error("supply verdict wrong");
  a_hv_blocked: assert property (i_prot_off |-> !o_hv_pick)
    else $error("high element timing under protection off");
  a_win_length: assert property (
    o_lv_state == vrs_pkg::ST_PASSIVE
    && $past(o_lv_state) == vrs_pkg::ST_RESET_WIN |-> win_q >= 99*TICK_CYC)
    else $error("reset window too short");
  c_lv_passive: cover property (o_lv_state == vrs_pkg::ST_PASSIVE);
  c_close: cover property (o_close_req);
  c_hv_lock: cover property (o_hv_pick ##[1:300] o_hv_state == 3'h0);
endmodule

bind vrs_top vrs_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .i_core_clk, .i_srst, .i_chk_en, .i_chk_ok, .i_live_work, .i_prot_off,
  .i_reclose_off, .o_trip_req, .o_close_req, .o_supply_good, .o_lv_state,
  .o_hv_state, .o_lv_pick, .o_hv_pick);

// ===== dv/vrs_act_model.sv
// partner: actuator driver moving the recloser on trip and close requests
`timescale 1ns/100ps
module vrs_act_model (
  input wire logic i_core_clk,
  input wire logic i_trip_req, // open request from the sequencer
  input wire logic i_close_req, // close request from the sequencer
  input wire logic i_man_close, // operator closing
  input wire logic [7:0] i_op_cyc, // travel time, short or long
  output logic o_rec_open
);
  int unsigned cnt_q = 0; // travel countdown
  logic tgt_q = 1'b1; // position being moved to
  initial o_rec_open = 1'b1;
  // a new request restarts travel; trip wins over close
  always @(posedge i_core_clk)
  begin
    if (cnt_q == 1)
      o_rec_open <= tgt_q;
    if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
    if (i_trip_req || i_close_req || i_man_close)
    begin
      tgt_q <= i_trip_req;
      cnt_q <= i_op_cyc;
    end
  end
endmodule

// ===== dv/vrs_top_test.sv
// testbench: sequencer with actuator model and request scoreboard
`timescale 1ns/100ps
module vrs_top_test;
  localparam int unsigned TC = 10; // short tick for simulation
  localparam logic [15:0] V_OK = 16'h03E8; // rated voltage
  logic i_core_clk, i_srst, i_rec_open, i_live_work, i_prot_off;
  logic i_reclose_off, i_src_minus, i_set_load, man_close;
  logic o_trip_req, o_close_req, o_supply_good, o_lv_pick, o_hv_pick;
  logic [15:0] volt, i_phase_volt;
  logic [4:0] i_chk_en, i_chk_ok;
  logic [7:0] op_cyc;
  vrs_pkg::vrs_trip_set_s i_lv_trip_plus, i_lv_trip_minus;
  vrs_pkg::vrs_trip_set_s i_hv_trip_plus, i_hv_trip_minus;
  vrs_pkg::vrs_rcl_set_s i_lv_rcl_plus, i_lv_rcl_minus;
  vrs_pkg::vrs_rcl_set_s i_hv_rcl_plus, i_hv_rcl_minus;
  vrs_pkg::vrs_rcl_state_e o_lv_state, o_hv_state;
  logic [1:0] exp_q[$]; // expected {trip, close} requests
  int errors = 0, n_tests = 0, cyc = 0, seed = 75;
  vrs_top #(.TICK_CYC(TC)) DUT (
    .i_core_clk, .i_srst, .i_pos_seq_voltage_src_a(volt), .i_phase_volt,
    .i_chk_en, .i_chk_ok, .i_rec_open, .i_live_work, .i_prot_off,
    .i_reclose_off, .i_src_minus, .i_set_load, .i_lv_trip_plus,
    .i_lv_trip_minus, .i_hv_trip_plus, .i_hv_trip_minus, .i_lv_rcl_plus,
    .i_lv_rcl_minus, .i_hv_rcl_plus, .i_hv_rcl_minus, .o_trip_req,
    .o_close_req, .o_supply_good, .o_lv_state, .o_hv_state, .o_lv_pick,
    .o_hv_pick);
  vrs_act_model u_act (.i_core_clk, .i_trip_req(o_trip_req),
    .i_close_req(o_close_req), .i_man_close(man_close), .i_op_cyc(op_cyc),
    .o_rec_open(i_rec_open));
  // ************************************************
  // helpers
  // ************************************************
  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // poll a controller state under a bound, then compare
  task automatic wait_st(input bit hv, vrs_pkg::vrs_rcl_state_e e, int lim);
    for (int k = 0; k < lim && (hv ? o_hv_state : o_lv_state) !== e; k++)
      step(1);
    chk(hv ? "hv_state" : "lv_state", e, hv ? o_hv_state : o_lv_state);
  endtask
  // random low voltage and random actuator speed
  task automatic low_v;
    volt = 16'(16'h0064 + $unsigned($random(seed)) % 600);
    op_cyc = 8'(2 + $unsigned($random(seed)) % 30);
  endtask
  task automatic close_rec;
    man_close = 1'b1;
    step(1);
    man_close = 1'b0;
  endtask
  // scoreboard: each request pulse takes the oldest note
  always @(negedge i_core_clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      errors++;
      give_verdict;
    end
    else if (o_trip_req || o_close_req)
      chk("request", exp_q.size() ? exp_q.pop_front() : 2'b00,
        {o_trip_req, o_close_req});
  end
  // ************************************************
  // scenarios
  // ************************************************
  initial
  begin
    i_srst = 1'b1;
    {i_live_work, i_prot_off, i_reclose_off, i_src_minus} = '0;
    {i_set_load, man_close} = '0;
    {volt, i_phase_volt} = {V_OK, V_OK};
    {i_chk_en, i_chk_ok, op_cyc} = {5'h1F, 5'h1F, 8'h04};
    i_lv_trip_plus = '{1'b1, 8'h50, 15'h000A};
    i_lv_trip_minus = '{1'b0, 8'h50, 15'($random(seed))};
    i_hv_trip_plus = '{1'b1, 8'h69, 15'h000A};
    i_hv_trip_minus = i_lv_trip_minus;
    i_lv_rcl_plus = '{1'b1, 15'h000A};
    i_lv_rcl_minus = i_lv_rcl_plus;
    i_hv_rcl_plus = '{1'b1, 15'h0003};
    i_hv_rcl_minus = i_hv_rcl_plus;
    step(10);
    i_srst = 1'b0;
    i_set_load = 1'b1;
    step(1);
    i_set_load = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      {i_chk_en, i_chk_ok} = {5'h1F, ~(5'h01 << i)};
      step(2);
      chk("supply_good", 0, o_supply_good);
      i_chk_en = i_chk_ok;
      step(2);
      chk("supply_good", 1, o_supply_good);
    end
    i_chk_en = 5'h1F;
    close_rec();
    wait_st(0, vrs_pkg::ST_RESET_WIN, 20);
    step(95 * TC);
    chk("lv_state", vrs_pkg::ST_RESET_WIN, o_lv_state);
    wait_st(0, vrs_pkg::ST_PASSIVE, 10 * TC);
    wait_st(1, vrs_pkg::ST_PASSIVE, 2);
    // two-shot reclose with supply held bad at first
    low_v();
    i_chk_ok = 5'h00;
    exp_q.push_back(2'b10);
    step(2);
    chk("lv_pick", 1, o_lv_pick);
    wait_st(0, vrs_pkg::ST_TRIP_PEND, 15 * TC);
    volt = V_OK;
    wait_st(0, vrs_pkg::ST_WAIT_SUPPLY, 60);
    step(50);
    chk("lv_state", vrs_pkg::ST_WAIT_SUPPLY, o_lv_state);
    exp_q.push_back(2'b01);
    i_chk_ok = 5'h1F;
    wait_st(0, vrs_pkg::ST_RCL_TIME, 4);
    wait_st(0, vrs_pkg::ST_CLOSE_PEND, 12 * TC);
    wait_st(0, vrs_pkg::ST_RESET_WIN, 60);
    low_v();
    step(3 * TC);
    volt = V_OK;
    wait_st(0, vrs_pkg::ST_PASSIVE, 110 * TC);
    // reclose, then low again inside the window
    low_v();
    exp_q.push_back(2'b10);
    wait_st(0, vrs_pkg::ST_TRIP_PEND, 15 * TC);
    volt = V_OK;
    exp_q.push_back(2'b01);
    wait_st(0, vrs_pkg::ST_CLOSE_PEND, 20 * TC);
    wait_st(0, vrs_pkg::ST_RESET_WIN, 60);
    low_v();
    exp_q.push_back(2'b10);
    wait_st(0, vrs_pkg::ST_LOCK, 15 * TC);
    volt = V_OK;
    wait_st(1, vrs_pkg::ST_LOCK, 60);
    // high voltage inside the first window
    close_rec();
    wait_st(1, vrs_pkg::ST_RESET_WIN, 60);
    volt = 16'h044C;
    exp_q.push_back(2'b10);
    step(2);
    chk("hv_pick", 1, o_hv_pick);
    wait_st(1, vrs_pkg::ST_LOCK, 15 * TC);
    wait_st(0, vrs_pkg::ST_LOCK, 60);
    volt = V_OK;
    for (int i = 0; i < 3; i++)
    begin
      close_rec();
      wait_st(1, vrs_pkg::ST_RESET_WIN, 60);
      {i_live_work, i_prot_off, i_reclose_off} = 3'b100 >> i;
      volt = i_prot_off ? 16'h04B0 : V_OK;
      step(2);
      chk("lv_state", vrs_pkg::ST_LOCK, o_lv_state);
      chk("hv_pick", 0, o_hv_pick);
      {i_live_work, i_prot_off, i_reclose_off, volt} = {3'b000, V_OK};
    end
    // minus direction has its low element disabled
    wait_st(0, vrs_pkg::ST_RESET_WIN, 20);
    i_src_minus = 1'b1;
    low_v();
    step(15 * TC);
    chk("lv_pick", 0, o_lv_pick);
    chk("lv_state", vrs_pkg::ST_RESET_WIN, o_lv_state);
    {i_src_minus, volt} = {1'b0, V_OK};
    // high trip recloses like the low sequence
    wait_st(1, vrs_pkg::ST_PASSIVE, 100 * TC);
    volt = 16'h044C;
    exp_q.push_back(2'b10);
    wait_st(1, vrs_pkg::ST_TRIP_PEND, 15 * TC);
    {volt, i_lv_rcl_plus.limit_two} = {V_OK, 1'b0};
    exp_q.push_back(2'b01);
    wait_st(1, vrs_pkg::ST_CLOSE_PEND, 20 * TC);
    // low limit back to one: one trip to lockout
    wait_st(0, vrs_pkg::ST_PASSIVE, 110 * TC);
    i_set_load = 1'b1;
    step(1);
    i_set_load = 1'b0;
    low_v();
    exp_q.push_back(2'b10);
    wait_st(0, vrs_pkg::ST_LOCK, 15 * TC);
    step(20);
    chk("queue", 0, exp_q.size());
    give_verdict();
  end
endmodule
